// File: src/sbg_pkg.sv
// Purpose: Shared constants and types for the system bus glue logic
// Assumes: 25 MHz processor clock
// Notes:   Cycle counts other than IDLE_CYCLES derive from times in their own units
package sbg_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int CAS_SETTLE_NS   = 565;
   localparam int SEL_VALID_NS    = 595;
   localparam int IDLE_CYCLES     = 4;
   // Least time rounds up; idle cycles already cover part of it
   localparam int SEL_CYCLES      =
      (SEL_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_WAIT_CYCLES = SEL_CYCLES - IDLE_CYCLES;
   localparam int TIMEOUT_MS      = 1;
   localparam int TIMEOUT_CYCLES  =
      TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CNT_W           = 16;
   localparam int WAIT_W          = 5;

   // -----------------------------------------------------------------
   // Cascade configuration and types
   // -----------------------------------------------------------------
   localparam int NUM_SLAVES      = 8;
   localparam int NUM_SOURCES     = 64;

   typedef enum logic [1:0] {
      SBG_CFG_ALL_LOCAL  = 2'h0,
      SBG_CFG_ALL_SYSTEM = 2'h1,
      SBG_CFG_SPLIT      = 2'h2
   } sbg_cfg_t;

   typedef struct packed {
      logic [2:0] code;
      logic       valid;
   } sbg_cascade_t;

   typedef struct packed {
      logic       high_byte_enable;
      logic       a0;
      logic       is_write;
   } sbg_lane_t;

endpackage

// File: src/sbg_glue.sv
// Purpose: Glue between the local processor bus and the system bus
// Assumes: Cascade, acknowledge and power-fail pins are asynchronous
// Notes:   Timeout counter replaces an analogue one-shot
`timescale 1ns/1ps

module sbg_glue (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rstn,
   // Configuration and slave placement
   input  wire sbg_pkg::sbg_cfg_t cfg,
   input  wire logic [7:0]       slave_on_system,
   // Interrupt acknowledge
   input  wire logic             interrupt_ack_strobe_n,
   input  wire logic             cascade_code_bit0_n,
   input  wire logic             cascade_code_bit1_n,
   input  wire logic             cascade_code_bit2_n,
   input  wire logic             addr_latched,
   output logic                  bus_select_system,
   output logic                  arbiter_enable,
   output logic [2:0]            addr_a10_a8_o,
   output logic                  cascade_address_drive_enable,
   output logic                  ack_wait_state,
   // System bus cycle
   input  wire logic             sys_cycle,
   input  wire logic             addr_latch_strobe,
   input  wire logic             remote_ack_n,
   output logic                  ready,
   output logic                  bus_timeout,
   output logic                  sixteen_bit_size_indication_n,
   // Byte lanes
   input  wire sbg_pkg::sbg_lane_t lane,
   output logic                  swap_oe,
   output logic                  low_oe,
   output logic                  high_oe,
   // Power fail
   input  wire logic             power_fail_n,
   output logic                  nmi_request
);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int NS = 6;
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   assign raw = {power_fail_n, remote_ack_n, cascade_code_bit2_n,
                 cascade_code_bit1_n, cascade_code_bit0_n,
                 interrupt_ack_strobe_n};

   // Two stages per asynchronous pin, idle high
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               s1_reg[gi] <= 1'b1;
               s2_reg[gi] <= 1'b1;
            end else begin
               s1_reg[gi] <= raw[gi];
               s2_reg[gi] <= s1_reg[gi];
            end
         end
      end
   endgenerate

   logic       ack_s;
   logic [2:0] cas_s;
   logic       rack_s;
   logic       pf_s;
   assign ack_s  = ~s2_reg[0];
   assign cas_s  = ~s2_reg[3:1];
   assign rack_s = ~s2_reg[4];
   assign pf_s   = ~s2_reg[5];

   // -----------------------------------------------------------------
   // Interrupt acknowledge sequencing
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {IDLE, FIRST, GAP, SECOND} sbg_ack_st_t;
   typedef logic [sbg_pkg::WAIT_W-1:0] sbg_wait_t;
   sbg_ack_st_t          st_reg;
   logic                 ack_d_reg;
   sbg_wait_t            wait_reg;
   logic                 ack_rise;
   logic                 ack_fall;
   assign ack_rise = ack_s & ~ack_d_reg;
   assign ack_fall = ~ack_s & ack_d_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_reg    <= IDLE;
         ack_d_reg <= 1'b0;
      end else begin
         ack_d_reg <= ack_s;
         case (st_reg)
            IDLE:    if (ack_rise) st_reg <= FIRST;
            FIRST:   if (ack_fall) st_reg <= GAP;
            GAP:     if (ack_rise) st_reg <= SECOND;
            SECOND:  if (ack_fall) st_reg <= IDLE;
            default: st_reg <= IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wait_reg <= '0;
      end else if (st_reg == IDLE && ack_rise) begin
         wait_reg <= sbg_wait_t'(sbg_pkg::ACK_WAIT_CYCLES);
      end else if (wait_reg != '0) begin
         wait_reg <= wait_reg - 1'b1;
      end
   end

   // wait request while counting
   // Holds the first cycle open until the select has settled
   assign ack_wait_state = (wait_reg != '0);

   // Bus select decode; 3-bit code spans all eight slaves
   // eight slaves addressed by code
   logic sel_next;
   always_comb begin
      case (cfg)
         sbg_pkg::SBG_CFG_ALL_LOCAL:  sel_next = 1'b0;
         sbg_pkg::SBG_CFG_ALL_SYSTEM: sel_next = 1'b1;
         sbg_pkg::SBG_CFG_SPLIT:      sel_next = slave_on_system[cas_s];
         default:                     sel_next = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bus_select_system <= 1'b0;
      end else if (st_reg == FIRST || st_reg == GAP) begin
         bus_select_system <= sel_next;
      end else if (st_reg == IDLE && !ack_rise) begin
         bus_select_system <= 1'b0;
      end
   end

   assign arbiter_enable = bus_select_system &
                           (st_reg == GAP || st_reg == SECOND);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         addr_a10_a8_o <= 3'h0;
      end else if (st_reg == GAP) begin
         addr_a10_a8_o <= cas_s;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cascade_address_drive_enable <= 1'b0;
      end else if (st_reg == GAP && ack_rise) begin
         cascade_address_drive_enable <= 1'b1;
      end else if (addr_latched || st_reg == IDLE) begin
         cascade_address_drive_enable <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Byte lane steering
   // -----------------------------------------------------------------
   // single high/low swap for either direction, by enable and A0
   // upper byte write moved to low lane
   // low lane read back to upper lane
   always_comb begin
      swap_oe = sys_cycle & lane.a0 & ~lane.high_byte_enable;
      low_oe  = sys_cycle & ~lane.a0;
      // Straight upper lane only for even-address words
      high_oe = sys_cycle & ~lane.a0 & ~lane.high_byte_enable;
   end

   // size indication on every system cycle
   assign sixteen_bit_size_indication_n = ~sys_cycle;

   // -----------------------------------------------------------------
   // Ready and bus timeout
   // -----------------------------------------------------------------
   logic [sbg_pkg::CNT_W-1:0] to_cnt_reg;
   logic                      to_run_reg;
   logic                      ready_next;
   logic                      rack_d_reg;
   typedef logic [sbg_pkg::CNT_W-1:0] sbg_cnt_t;

   // timeout also forces ready
   // Edge, not level: the released line lingers in the synchroniser
   assign ready_next = sys_cycle & ~ready &
                       ((rack_s & ~rack_d_reg) | bus_timeout);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ready      <= 1'b0;
         rack_d_reg <= 1'b0;
      end else begin
         ready      <= ready_next;
         rack_d_reg <= rack_s;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         to_cnt_reg <= '0;
         to_run_reg <= 1'b0;
      end else if (addr_latch_strobe) begin
         to_cnt_reg <= sbg_cnt_t'(sbg_pkg::TIMEOUT_CYCLES - 1);
         to_run_reg <= 1'b1;
      end else if (ready || to_cnt_reg == '0) begin
         to_run_reg <= 1'b0;
      end else if (to_run_reg) begin
         to_cnt_reg <= to_cnt_reg - 1'b1;
      end
   end

   // expiry sets flag, ready clears it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bus_timeout <= 1'b0;
      end else if (to_run_reg && to_cnt_reg == '0 && !ready) begin
         bus_timeout <= 1'b1;
      end else if (ready) begin
         bus_timeout <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Power fail
   // -----------------------------------------------------------------
   // power fail drives non-maskable request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         nmi_request <= 1'b0;
      end else begin
         nmi_request <= pf_s;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_local_no_sel: assert property (
      cfg == sbg_pkg::SBG_CFG_ALL_LOCAL && st_reg == SECOND
      |-> !bus_select_system) else $error("local cfg selected system");
   a_system_sel: assert property (
      cfg == sbg_pkg::SBG_CFG_ALL_SYSTEM && st_reg == SECOND
      |-> bus_select_system) else $error("system cfg not selected");
   a_arb_enable: assert property (
      st_reg == SECOND && bus_select_system |-> arbiter_enable)
      else $error("arbiter not enabled");
   a_wait_load: assert property (
      st_reg == IDLE && ack_rise |=>
      wait_reg == sbg_wait_t'(sbg_pkg::ACK_WAIT_CYCLES))
      else $error("wait count wrong");
   a_drive_drop: assert property (
      addr_latched && !(st_reg == GAP && ack_rise)
      |=> !cascade_address_drive_enable)
      else $error("drive enable not removed");
   a_size_ind: assert property (
      sys_cycle |-> !sixteen_bit_size_indication_n)
      else $error("size indication missing");
   a_swap_excl: assert property (
      !(swap_oe && low_oe)) else $error("two lanes drive low byte");
   a_ack_ready: assert property (
      sys_cycle && rack_s && !rack_d_reg && !ready |=> ready)
      else $error("ready not after acknowledge");
   a_ready_pulse: assert property (
      ready |=> !ready) else $error("ready held two cycles");
   a_timeout_set: assert property (
      to_run_reg && to_cnt_reg == '0 && !ready |=> bus_timeout)
      else $error("timeout not flagged");
   a_timeout_clr: assert property (
      ready && !addr_latch_strobe && !(to_run_reg && to_cnt_reg == '0)
      |=> !bus_timeout) else $error("timeout not cleared");
   a_nmi_follow: assert property (
      pf_s |=> nmi_request) else $error("nmi not raised");

   c_two_acks: cover property (st_reg == SECOND);
   c_split_sys: cover property (cfg == sbg_pkg::SBG_CFG_SPLIT &&
                                arbiter_enable);
   c_timeout: cover property (bus_timeout);
   c_swap: cover property (swap_oe);

endmodule // sbg_glue

// File: verification/sbg_bus_model.sv
// Purpose: Far side of the system bus: remote slave and address latches
// Assumes: One transfer outstanding at a time
// Notes:   Ack delay 0 models an absent slave that never answers
`timescale 1ns/1ps

module sbg_bus_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Local side
   input  wire logic       addr_latch_strobe,
   input  wire logic       ready,
   input  wire logic       drive_en,
   input  wire logic [7:0] ack_delay,
   // Far side answers
   output logic            remote_ack_n,
   output logic            addr_latched
);
   // ----------------------------------------------------------------
   // Remote slave and latches
   // ----------------------------------------------------------------
   logic [7:0] cnt_reg;
   logic       busy_reg;
   logic       en_d_reg;

   // remote acknowledge
   // Held until ready; the released line floats back to its pull-up
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busy_reg     <= 1'b0;
         cnt_reg      <= 8'h00;
         remote_ack_n <= 1'b1;
      end else if (ready) begin
         busy_reg     <= 1'b0;
         remote_ack_n <= 1'b1;
      end else if (addr_latch_strobe) begin
         busy_reg <= 1'b1;
         cnt_reg  <= ack_delay;
      end else if (busy_reg && cnt_reg != 8'h00) begin
         cnt_reg      <= cnt_reg - 8'h01;
         remote_ack_n <= cnt_reg != 8'h01;
      end
   end

   // latch capture
   // Needs two cycles of enable, so an early drop goes uncaptured
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         en_d_reg     <= 1'b0;
         addr_latched <= 1'b0;
      end else begin
         en_d_reg     <= drive_en;
         addr_latched <= drive_en && en_d_reg;
      end
   end
endmodule // sbg_bus_model

// File: verification/tb.sv
// Purpose: Self-checking bench for the system bus glue logic
// Assumes: Hand-over timing; xorshift seed 36
// Notes:   Timeout runs its full count, about 25000 cycles
`timescale 1ns/1ps

module tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int TO = sbg_pkg::TIMEOUT_CYCLES;
   logic               mclk, rstn, sys_cycle, addr_latch_strobe;
   logic               interrupt_ack_strobe_n, addr_latched;
   logic               cascade_code_bit0_n, cascade_code_bit1_n;
   logic               cascade_code_bit2_n, remote_ack_n, power_fail_n;
   logic               bus_select_system, arbiter_enable, ready;
   logic               cascade_address_drive_enable, bus_timeout;
   logic               ack_wait_state;
   logic               sixteen_bit_size_indication_n, nmi_request;
   logic               swap_oe, low_oe, high_oe;
   logic [2:0]         addr_a10_a8_o;
   logic [7:0]         slave_on_system, ack_delay;
   logic [31:0]        seed, r;
   sbg_pkg::sbg_cfg_t  cfg;
   sbg_pkg::sbg_lane_t lane;
   int                 num_errors, check_count;

   // Design and far-side model
   sbg_glue dut (
      .mclk, .rstn, .cfg, .slave_on_system, .interrupt_ack_strobe_n,
      .cascade_code_bit0_n, .cascade_code_bit1_n, .cascade_code_bit2_n,
      .addr_latched, .bus_select_system, .arbiter_enable, .addr_a10_a8_o,
      .cascade_address_drive_enable, .sys_cycle, .addr_latch_strobe,
      .remote_ack_n, .ready, .bus_timeout, .sixteen_bit_size_indication_n,
      .lane, .swap_oe, .low_oe, .high_oe, .power_fail_n, .nmi_request,
      .ack_wait_state
   );
   sbg_bus_model far (
      .mclk, .rstn, .addr_latch_strobe, .ready, .ack_delay,
      .drive_en(cascade_address_drive_enable), .remote_ack_n, .addr_latched
   );

   // Clock at 25 MHz
   initial mclk = 1'b0;
   always #20 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk_bit(input string what, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk_code(input string what, input logic [2:0] e,
                           input logic [2:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Enables {swap, low, high}; a byte at an odd address needs the swap
   function automatic logic [2:0] lane_exp(input logic s,
                                           input sbg_pkg::sbg_lane_t l);
      return {s & l.a0 & ~l.high_byte_enable, s & ~l.a0,
              s & ~l.a0 & ~l.high_byte_enable};
   endfunction

   task automatic set_cas(input logic [2:0] v);
      cascade_code_bit0_n <= v[0];
      cascade_code_bit1_n <= v[1];
      cascade_code_bit2_n <= v[2];
   endtask

   // Both acknowledge cycles for one cascade code
   task automatic iack(input sbg_pkg::sbg_cfg_t c, input logic [2:0] code);
      logic e;
      int   n;
      int   w;
      e = (c == sbg_pkg::SBG_CFG_SPLIT) ? slave_on_system[code]
                                        : (c == sbg_pkg::SBG_CFG_ALL_SYSTEM);
      n = 0;
      w = 0;
      @(posedge mclk);
      cfg <= c;
      set_cas(~code);
      interrupt_ack_strobe_n <= 1'b0;
      // First strobe ten cycles, then six idle; wait requests counted
      for (int i = 0; i < 16; i++) begin
         @(negedge mclk);
         w += int'(ack_wait_state);
         @(posedge mclk);
         if (i == 9) interrupt_ack_strobe_n <= 1'b1;
      end
      interrupt_ack_strobe_n <= 1'b0;
      while (!cascade_address_drive_enable && n < 8) begin
         @(negedge mclk);
         n++;
      end
      chk_bit("drive_on", 1'b1, cascade_address_drive_enable);
      chk_bit("bus_sel", e, bus_select_system);
      chk_bit("arb_en", e, arbiter_enable);
      chk_code("cas_addr", code, addr_a10_a8_o);
      while (cascade_address_drive_enable && n < 16) begin
         @(negedge mclk);
         n++;
      end
      chk_bit("drive_off", 1'b0, cascade_address_drive_enable);
      chk_bit("latched", 1'b1, addr_latched);
      @(posedge mclk);
      interrupt_ack_strobe_n <= 1'b1;
      set_cas(code);
      // Select clears one edge after the return to idle
      repeat (5) @(negedge mclk);
      chk_bit("sel_idle", 1'b0, bus_select_system);
      chk_bit("ack_wait", 1'b1, w == sbg_pkg::ACK_WAIT_CYCLES);
   endtask

   // One system-bus cycle; delay 0 leaves it to the bus timeout counter
   task automatic xfer(input logic [7:0] d);
      int n, tf, tr, pulses;
      n = 0;
      tf = 0;
      tr = 0;
      pulses = 0;
      @(posedge mclk);
      sys_cycle <= 1'b1;
      ack_delay <= d;
      addr_latch_strobe <= 1'b1;
      @(posedge mclk);
      addr_latch_strobe <= 1'b0;
      while (n < ((d == 8'h00) ? TO + 20 : 60)) begin
         @(negedge mclk);
         n++;
         if (bus_timeout && tf == 0) tf = n;
         if (ready) pulses++;
         if (ready && tr == 0) tr = n;
      end
      if (d == 8'h00) begin
         chk_bit("tmo_time", 1'b1,
                 tf >= TO - 1 && tf <= TO + 1);
         chk_bit("ready_after", 1'b1, tr > tf);
      end else
         chk_bit("no_tmo", 1'b1, tf == 0);
      chk_bit("one_ready", 1'b1, pulses == 1);
      chk_bit("tmo_clear", 1'b0, bus_timeout);
      @(posedge mclk);
      sys_cycle <= 1'b0;
   endtask

   task automatic final_report();
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h0000_0024;
      num_errors = 0;
      check_count = 0;
      rstn = 1'b0;
      cfg = sbg_pkg::SBG_CFG_ALL_LOCAL;
      slave_on_system = 8'h00;
      interrupt_ack_strobe_n = 1'b1;
      {cascade_code_bit2_n, cascade_code_bit1_n, cascade_code_bit0_n} = 3'h7;
      sys_cycle = 1'b0;
      addr_latch_strobe = 1'b0;
      ack_delay = 8'h00;
      lane = '0;
      power_fail_n = 1'b1;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      // Lanes, size indication and power fail, random
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         @(posedge mclk);
         lane <= sbg_pkg::sbg_lane_t'(r[2:0]);
         sys_cycle <= r[3];
         power_fail_n <= r[4];
         @(negedge mclk);
         chk_code("lane_oe", lane_exp(sys_cycle, lane),
                  {swap_oe, low_oe, high_oe});
         chk_bit("size16_n", ~sys_cycle, sixteen_bit_size_indication_n);
         repeat (3) @(negedge mclk);
         chk_bit("nmi", ~power_fail_n, nmi_request);
      end
      // Every configuration and every cascade code, eight slaves, one random placement
      r = rnd();
      @(posedge mclk);
      sys_cycle <= 1'b0;
      slave_on_system <= r[7:0];
      for (int c = 0; c < 3; c++)
         for (int k = 0; k < 8; k++)
            iack(sbg_pkg::sbg_cfg_t'(c[1:0]), k[2:0]);
      // Quickest, slow, random and absent slaves
      for (int i = 0; i < 7; i++) begin
         r = rnd();
         xfer(i == 0 ? 8'h01 : i == 1 ? 8'h1e : i == 6 ? 8'h00
              : ({3'h0, r[4:0]} | 8'h01));
      end
      final_report();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (TO + 15000) @(posedge mclk);
      num_errors++;
      final_report();
   end
endmodule // tb
